//--- bench/pmcc_monitor.sv
// Purpose: port checks for pmcc_top
// Assumes: fast oscillator period of 4 clk
// Notes: start-up length is counted in clk cycles
module pmcc_monitor #(
    parameter int unsigned timer_width = pmcc_pkg::idle_timer_width,
    parameter int unsigned min_start = 5120
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic fast_osc_enable,
    input wire logic slow_osc_enable,
    input wire logic fast_clk_run,
    input wire logic core_clk_run,
    input wire logic core_on_slow,
    input wire logic idle_timer_on_fast,
    input wire logic idle_timer_run,
    input wire logic cpu_exec_en,
    input wire logic irq_idle_timer,
    input wire pmcc_pkg::pmcc_state_t pm_state
);
    import pmcc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [12:0] cnt_q;
    logic [12:0] cnt_d;
    assign cnt_d = (pm_state == pmcc_run_t_start) ? cnt_q + 13'h1 : 13'h0;
    always_ff @(posedge clk) begin
        cnt_q <= rst ? 13'h0 : cnt_d;
    end
    sequence s_start_end;
        !$past(rst) && $fell(pm_state == pmcc_run_t_start);
    endsequence
    sequence s_idle_end;
        !$past(rst) && $fell(pm_state == pmcc_run_t_idle) && !core_on_slow;
    endsequence
    a_start_len: assert property (s_start_end |-> cnt_q >= min_start)
        else $error("start-up delay too short");
    a_start_fast: assert property (pm_state == pmcc_run_t_start |->
        idle_timer_on_fast && !cpu_exec_en) else $error("start-up clocking");
    a_halt_core: assert property (pm_state == pmcc_run_t_halt |->
        !core_clk_run && !cpu_exec_en) else $error("core runs in halt");
    a_halt_clocks: assert property (pm_state == pmcc_run_t_halt &&
        !core_on_slow |-> !fast_clk_run && slow_osc_enable && !idle_timer_run)
        else $error("dual halt clocking");
    a_slow_halt: assert property (pm_state == pmcc_run_t_halt &&
        core_on_slow |-> slow_osc_enable && !idle_timer_run)
        else $error("low-speed halt clocking");
    a_idle_runs: assert property (pm_state == pmcc_run_t_idle |->
        !cpu_exec_en && slow_osc_enable && idle_timer_run)
        else $error("idle clocking");
    a_idle_exit: assert property (s_idle_end |->
        pm_state == pmcc_run_t_run && cpu_exec_en) else $error("idle exit");
    a_run_exec: assert property (pm_state == pmcc_run_t_run |->
        cpu_exec_en && core_clk_run) else $error("run clocking");
    a_timer_slow: assert property (s_start_end ##0 slow_osc_enable |->
        !idle_timer_on_fast) else $error("timer left on fast clock");
    a_irq_wakes: assert property ($rose(irq_idle_timer) |->
        pm_state != pmcc_run_t_idle) else $error("idle kept after event");
    a_pin_reset: assert property (!reset_pin_n [*6] |->
        pm_state == pmcc_run_t_run && fast_osc_enable && !core_on_slow)
        else $error("pin reset not applied");
endmodule : pmcc_monitor
bind pmcc_top pmcc_monitor #(.timer_width(timer_width)) i_pmcc_monitor (
    .clk(clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable),
    .fast_clk_run(fast_clk_run), .core_clk_run(core_clk_run),
    .core_on_slow(core_on_slow), .idle_timer_on_fast(idle_timer_on_fast),
    .idle_timer_run(idle_timer_run), .cpu_exec_en(cpu_exec_en),
    .irq_idle_timer(irq_idle_timer),
    .pm_state(pm_state));

//--- bench/pmcc_partner.sv
// Purpose: oscillators and instruction timing beside pmcc_top
// Assumes: fast and slow oscillator periods of 4 clk
// Notes: amplitude good 32 cycles after the fast oscillator enable
module pmcc_partner (
    input wire logic clk,
    input wire logic fast_osc_enable,
    output logic fast_osc_input,
    output logic fast_osc_amp_ok,
    output logic slow_osc_tick,
    output logic instr_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_q;
    logic [4:0] amp_q;
    initial begin
        div_q = 2'h0;
        amp_q = 5'h0;
        {fast_osc_input, fast_osc_amp_ok, slow_osc_tick, instr_done} = 4'h0;
    end
    always @(posedge clk) begin
        div_q <= div_q + 2'h1;
        amp_q <= fast_osc_enable ? amp_q + {4'h0, ~&amp_q} : 5'h0;
        fast_osc_amp_ok <= &amp_q;
        if (div_q[0]) begin
            fast_osc_input <= fast_osc_enable & ~fast_osc_input;
        end
        slow_osc_tick <= div_q[1];
        instr_done <= &div_q;
    end
endmodule : pmcc_partner

//--- bench/power_mode_clock_controller_tb_top.sv
// Purpose: self-checking bench for pmcc_top
// Assumes: partner oscillator periods of 4 clk
// Notes: start-up takes about 5140 cycles
module power_mode_clock_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmcc_pkg::*;
    logic clk, rst, reg_wr, reg_rd, reset_pin_n, wake_event, halt_dis;
    logic fast_in, amp_ok, slow_tick, instr_done, fast_en, on_slow, exec_en;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    pmcc_state_t pm_state;
    logic irq;
    int failures = 0;
    int compares = 0;
    pmcc_top i_pmcc_top (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reset_pin_n(reset_pin_n),
        .wake_event(wake_event), .halt_disable_opt(halt_dis),
        .fast_osc_input(fast_in), .fast_osc_amp_ok(amp_ok),
        .slow_osc_tick(slow_tick), .instr_done(instr_done),
        .fast_osc_enable(fast_en), .slow_osc_enable(), .fast_clk_run(),
        .core_clk_run(), .core_on_slow(on_slow), .idle_timer_on_fast(),
        .idle_timer_run(), .cpu_exec_en(exec_en), .irq_idle_timer(irq),
        .pm_state(pm_state));
    pmcc_partner i_pmcc_partner (.clk(clk), .fast_osc_enable(fast_en),
        .fast_osc_input(fast_in), .fast_osc_amp_ok(amp_ok),
        .slow_osc_tick(slow_tick), .instr_done(instr_done));
    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
        @(posedge clk);
    endtask : rd
    task automatic wait_st(input pmcc_state_t st, input int n);
        for (int i = 0; i < n && pm_state !== st; i++) @(posedge clk);
        check({4'h0, pm_state}, {4'h0, st});
    endtask : wait_st
    task automatic wake();
        wake_event <= 1'b1;
        repeat (4) @(posedge clk);
        wake_event <= 1'b0;
    endtask : wake
    task automatic t_reset();
        rd(addr_clk_ctrl, clk_ctrl_rst);
        rd(addr_win_mode, 8'h00);
        rd(addr_status, 8'h01);
        rd(4'hf, 8'h00);
        wr(addr_clk_ctrl, 8'h0e);
        rd(addr_clk_ctrl, 8'h02);
        wr(addr_clk_ctrl, 8'h03);
        wr(addr_clk_ctrl, 8'h07);
        rd(addr_clk_ctrl, 8'h07);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_halt();
        halt_dis <= 1'b1;
        wr(addr_port_g, 8'h80);
        repeat (20) @(posedge clk);
        wait_st(pmcc_run_t_run, 1);
        halt_dis <= 1'b0;
        wr(addr_port_g, 8'h80);
        wait_st(pmcc_run_t_halt, 20);
        wake();
        wait_st(pmcc_run_t_start, 10);
        wait_st(pmcc_run_t_run, 6000);
        wr(addr_port_g, 8'h80);
        wait_st(pmcc_run_t_halt, 20);
        reset_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        reset_pin_n <= 1'b1;
        wait_st(pmcc_run_t_run, 8);
        repeat (6) @(posedge clk);
        rd(addr_clk_ctrl, clk_ctrl_rst);
        $display("t_halt done");
    endtask : t_halt
    task automatic t_idle();
        wr(addr_clk_ctrl, 8'h03);
        wr(addr_clk_ctrl, 8'h07);
        wr(addr_win_mode, 8'h04);
        wr(addr_win_mode, 8'h05);
        rd(addr_win_mode, 8'h04);
        wr(addr_int_ctrl, 8'h00);
        wr(addr_port_g, 8'h40);
        wait_st(pmcc_run_t_idle, 20);
        wake();
        wait_st(pmcc_run_t_run, 20);
        check({7'h0, on_slow}, 8'h00);
        check({7'h0, exec_en}, 8'h01);
        $display("t_idle done");
    endtask : t_idle
    task automatic t_window();
        // irq off, new window, then irq on
        wr(addr_int_ctrl, 8'h00);
        wr(addr_win_mode, 8'h00);
        wr(addr_int_ctrl, 8'h01);
        wr(addr_port_g, 8'h40);
        wait_st(pmcc_run_t_idle, 20);
        wait_st(pmcc_run_t_run, 17000);
        rd(addr_int_ctrl, 8'h03);
        check({7'h0, irq}, 8'h01);
        wr(addr_int_ctrl, 8'h02);
        check({7'h0, irq}, 8'h00);
        wr(addr_int_ctrl, 8'h00);
        $display("t_window done");
    endtask : t_window
    task automatic t_low();
        wr(addr_clk_ctrl, 8'h0f);
        wr(addr_clk_ctrl, 8'h0d);
        rd(addr_clk_ctrl, 8'h0d);
        check({6'h0, fast_en, on_slow}, 8'h01);
        wr(addr_port_g, 8'h80);
        wait_st(pmcc_run_t_halt, 20);
        wake();
        wait_st(pmcc_run_t_run, 10);
        reset_pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd(addr_clk_ctrl, clk_ctrl_rst);
        wr(addr_clk_ctrl, 8'h0a);
        rd(addr_clk_ctrl, 8'h02);
        $display("t_low done");
    endtask : t_low
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {rst, reg_wr, reg_rd, wake_event, halt_dis} = 5'h10;
        reset_pin_n = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_halt();
        t_idle();
        t_window();
        t_low();
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        end_of_test();
    end
endmodule : power_mode_clock_controller_tb_top

//--- verilog/pmcc_pkg.sv
// Purpose: constants for the power mode clock controller
// Assumes: 200 MHz system clock, register port with 8-bit data
// Notes: offsets are word indices on the plain register port
package pmcc_pkg;
    localparam int unsigned clk_period_ps = 5000;
    localparam logic [3:0] addr_port_g = 4'h0;
    localparam logic [3:0] addr_int_ctrl = 4'h1;
    localparam logic [3:0] addr_win_mode = 4'h2;
    localparam logic [3:0] addr_clk_ctrl = 4'h3;
    localparam logic [3:0] addr_status = 4'h4;
    localparam int unsigned bit_halt_req = 7;
    localparam int unsigned bit_idle_req = 6;
    localparam int unsigned bit_irq_en = 0;
    localparam int unsigned bit_pend = 1;
    localparam int unsigned bit_slow_on = 0;
    localparam int unsigned bit_fast_on = 1;
    localparam int unsigned bit_dual = 2;
    localparam int unsigned bit_core_sel = 3;
    localparam int unsigned bit_dly_sel = 4;
    localparam logic [2:0] win_mode_rst = 3'h0;
    localparam logic [7:0] clk_ctrl_rst = 8'h02;
    localparam logic [8:0] startup_load = 9'h100;
    localparam int unsigned instr_div = 5;
    localparam logic [2:0] instr_div_last = 3'h4;
    localparam int unsigned win_tap_base = 12;
    localparam int unsigned win_count = 5;
    localparam int unsigned idle_timer_width = 17;
    typedef enum logic [3:0] {
        pmcc_run_t_run = 4'b0001,
        pmcc_run_t_halt = 4'b0010,
        pmcc_run_t_start = 4'b0100,
        pmcc_run_t_idle = 4'b1000
    } pmcc_state_t;
endpackage : pmcc_pkg

//--- verilog/pmcc_top.sv
// Purpose: halt, idle and clock mode sequencing for the core
// Assumes: slow and fast oscillator ticks arrive as async pin levels
// Notes: idle timer taps start at bit 12 of the slow-clock counter
//
// Contract
// - writing halt bit 7 stops the core within the next instruction.
// - dual-clock halt stops fast clock, keeps slow osc, idle timer unclocked.
// - halt ends on chip reset pin or on a wake-up event.
// - low reset pin exits halt, clears dual mode, selects high speed.
// - dual-clock halt wake-up always applies the start-up delay.
// - start-up loads 256, counts instruction cycles, releases at underflow.
// - start-up count advances only while oscillator amplitude is good.
// - after dual-clock start-up the idle timer returns to the slow clock.
// - halt-disable option makes halt writes ignored.
// - idle bit 6 stops execution; oscillators and idle timer keep running.
// - leaving dual-clock idle resumes execution on the fast clock.
// - window select offers five periods, 0.125 s up to 2 s.
// - in dual-clock mode the idle timer counts slow ticks except in halt and start-up.
// - selected tap toggle sets pending, raises enabled irq, ends idle.
// - with irq enabled, finish current instruction then service interrupt.
// - idle timer is not software controllable; rst clears it to zero.
// - idle timer interrupt only while its enable bit is set.
// - low-speed entry from dual mode: core select, then fast osc off.
// - low-speed mode keeps slow osc always; idle timer stops in halt.
// - dual mode: core on fast clock, timer slow; needs slow osc first.
module pmcc_top #(
    parameter int unsigned timer_width = pmcc_pkg::idle_timer_width
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic reset_pin_n,
    input wire logic wake_event,
    input wire logic halt_disable_opt,
    input wire logic fast_osc_input,
    input wire logic fast_osc_amp_ok,
    input wire logic slow_osc_tick,
    input wire logic instr_done,
    output logic fast_osc_enable,
    output logic slow_osc_enable,
    output logic fast_clk_run,
    output logic core_clk_run,
    output logic core_on_slow,
    output logic idle_timer_on_fast,
    output logic idle_timer_run,
    output logic cpu_exec_en,
    output logic irq_idle_timer,
    output pmcc_pkg::pmcc_state_t pm_state
);
    import pmcc_pkg::*;

    // pin synchronisers: three stages, change on agreement of last two
    localparam int unsigned sync_pins = 5;
    wire [sync_pins-1:0] pin_raw = {slow_osc_tick, fast_osc_input,
        fast_osc_amp_ok, wake_event, reset_pin_n};
    wire [sync_pins-1:0] pin_lvl;
    generate
        for (genvar gi = 0; gi < sync_pins; gi++) begin : g_sync
            logic [2:0] stage_q;
            logic lvl_q;
            always_ff @(posedge clk) begin
                stage_q <= {stage_q[1:0], pin_raw[gi]};
                if (stage_q[2] == stage_q[1]) begin
                    lvl_q <= stage_q[2];
                end
            end
            assign pin_lvl[gi] = lvl_q;
        end
    endgenerate
    wire rpin_q = pin_lvl[0];
    wire wake_lvl_q = pin_lvl[1];
    wire amp_q = pin_lvl[2];
    wire osc_q = pin_lvl[3];
    wire slow_q = pin_lvl[4];

    logic osc_prev_q, slow_prev_q, wake_prev_q;
    always_ff @(posedge clk) begin
        osc_prev_q <= osc_q;
        slow_prev_q <= slow_q;
        wake_prev_q <= wake_lvl_q;
    end
    wire osc_rise = osc_q & ~osc_prev_q;
    wire slow_rise = slow_q & ~slow_prev_q;
    wire wake_rise = wake_lvl_q & ~wake_prev_q;
    wire pin_reset = ~rpin_q;
    wire any_reset = rst | pin_reset;

    // registers
    logic [7:0] clk_ctrl_q;
    logic [2:0] win_mode_q;
    logic irq_en_q, pend_q;
    pmcc_state_t state_q, state_d;
    logic [8:0] start_cnt_q;
    logic [2:0] div_q;
    logic [timer_width-1:0] itimer_q;
    logic tap_prev_q;

    wire wr_port_g = reg_wr && (reg_addr == addr_port_g);
    wire wr_int = reg_wr && (reg_addr == addr_int_ctrl);
    wire wr_win = reg_wr && (reg_addr == addr_win_mode);
    wire wr_clk = reg_wr && (reg_addr == addr_clk_ctrl);

    wire dual_mode = clk_ctrl_q[bit_dual];
    wire low_speed = clk_ctrl_q[bit_core_sel] & ~clk_ctrl_q[bit_fast_on];
    wire in_run = (state_q == pmcc_run_t_run);
    wire halt_req = wr_port_g && reg_wdata[bit_halt_req] && in_run
        && !halt_disable_opt;
    wire idle_req = wr_port_g && reg_wdata[bit_idle_req] && in_run
        && !reg_wdata[bit_halt_req];

    // clock control bits
    logic [7:0] clk_wr_val;
    always_comb begin
        clk_wr_val = reg_wdata;
        if (!dual_mode) begin
            clk_wr_val[bit_core_sel] = 1'b0;
        end
        // fast osc off only after core select
        if (!clk_ctrl_q[bit_core_sel]) begin
            clk_wr_val[bit_fast_on] = 1'b1;
        end
        if (!clk_ctrl_q[bit_slow_on]) begin
            clk_wr_val[bit_dual] = 1'b0;
        end
        // slow osc stays on in low speed
        if (clk_ctrl_q[bit_core_sel]) begin
            clk_wr_val[bit_slow_on] = 1'b1;
        end
        clk_wr_val[7:5] = 3'h0;
    end

    // reset pin returns to high speed
    always_ff @(posedge clk) begin
        if (any_reset) begin
            clk_ctrl_q <= clk_ctrl_rst;
        end else if (wr_clk) begin
            clk_ctrl_q <= clk_wr_val;
        end
    end

    always_ff @(posedge clk) begin
        if (any_reset) begin
            win_mode_q <= win_mode_rst;
        end else if (wr_win) begin
            win_mode_q <= (reg_wdata[2:0] < 3'(win_count)) ?
                reg_wdata[2:0] : win_mode_q;
        end
    end

    // instruction-cycle divider on the fast oscillator
    always_ff @(posedge clk) begin
        if (rst) begin
            div_q <= 3'h0;
        end else if (osc_rise) begin
            div_q <= (div_q == instr_div_last) ? 3'h0 : div_q + 3'h1;
        end
    end
    wire instr_tick = osc_rise && (div_q == instr_div_last);

    // idle timer: free running, not readable
    wire halted = (state_q == pmcc_run_t_halt);
    // no idle timer clock in halt
    wire itimer_src = idle_timer_on_fast ? instr_tick : slow_rise;
    wire itimer_tick = itimer_src && !halted && (state_q != pmcc_run_t_start);
    // chip reset only, no software access
    always_ff @(posedge clk) begin
        if (rst) begin
            itimer_q <= '0;
        end else if (itimer_tick) begin
            itimer_q <= itimer_q + 1'b1;
        end
    end

    function automatic logic tap_sel(input logic [timer_width-1:0] t,
                                     input logic [2:0] sel);
        tap_sel = t[win_tap_base + int'(sel)];
    endfunction : tap_sel

    wire tap_now = tap_sel(itimer_q, win_mode_q);
    always_ff @(posedge clk) begin
        tap_prev_q <= tap_now;
    end
    wire win_event = (tap_now != tap_prev_q) && !halted;

    always_ff @(posedge clk) begin
        if (any_reset) begin
            pend_q <= 1'b0;
            irq_en_q <= 1'b0;
        end else begin
            if (wr_int) begin
                irq_en_q <= reg_wdata[bit_irq_en];
            end
            if (win_event) begin
                pend_q <= 1'b1;
            end else if (wr_int) begin
                pend_q <= reg_wdata[bit_pend];
            end
        end
    end
    assign irq_idle_timer = pend_q & irq_en_q;

    wire start_done = (start_cnt_q == 9'h000) && instr_tick && amp_q;
    always_ff @(posedge clk) begin
        if (any_reset) begin
            start_cnt_q <= startup_load;
        end else if (state_q == pmcc_run_t_halt) begin
            start_cnt_q <= startup_load;
        end else if (state_q == pmcc_run_t_start && instr_tick && amp_q) begin
            start_cnt_q <= start_cnt_q - 9'h001;
        end
    end

    logic halt_pend_q, idle_pend_q;
    always_ff @(posedge clk) begin
        if (any_reset || !in_run) begin
            halt_pend_q <= 1'b0;
            idle_pend_q <= 1'b0;
        end else begin
            halt_pend_q <= halt_pend_q | halt_req;
            idle_pend_q <= idle_pend_q | idle_req;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            pmcc_run_t_run: begin
                if (halt_pend_q && instr_done) begin
                    state_d = pmcc_run_t_halt;
                end else if (idle_pend_q && instr_done) begin
                    state_d = pmcc_run_t_idle;
                end
            end
            pmcc_run_t_halt: begin
                if (wake_rise) begin
                    state_d = (low_speed || !dual_mode && !clk_ctrl_q[
                        bit_dly_sel]) ? pmcc_run_t_run : pmcc_run_t_start;
                end
                if (!low_speed && dual_mode && wake_rise) begin
                    state_d = pmcc_run_t_start;
                end
            end
            pmcc_run_t_start: begin
                if (start_done) begin
                    state_d = pmcc_run_t_run;
                end
            end
            pmcc_run_t_idle: begin
                if (win_event || wake_rise) begin
                    state_d = pmcc_run_t_run;
                end
            end
            default: state_d = pmcc_run_t_run;
        endcase
    end

    always_ff @(posedge clk) begin
        if (any_reset) begin
            state_q <= pmcc_run_t_run;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs
    assign pm_state = state_q;
    assign fast_osc_enable = clk_ctrl_q[bit_fast_on] && !halted;
    assign slow_osc_enable = clk_ctrl_q[bit_slow_on] || low_speed;
    assign fast_clk_run = clk_ctrl_q[bit_fast_on] && !halted;
    assign core_clk_run = in_run;
    assign cpu_exec_en = in_run;
    // fast core clock unless core select is set
    assign core_on_slow = clk_ctrl_q[bit_core_sel];
    // timer on fast clock in start-up
    assign idle_timer_on_fast = (state_q == pmcc_run_t_start) || !dual_mode
        && !low_speed;
    assign idle_timer_run = !halted;

    // register read port, data one cycle later
    logic [7:0] rd_val;
    always_comb begin
        if (reg_addr == addr_port_g) begin
            rd_val = {halt_pend_q, idle_pend_q, 6'h00};
        end else if (reg_addr == addr_int_ctrl) begin
            rd_val = {6'h00, pend_q, irq_en_q};
        end else if (reg_addr == addr_win_mode) begin
            rd_val = {5'h00, win_mode_q};
        end else if (reg_addr == addr_clk_ctrl) begin
            rd_val = clk_ctrl_q;
        end else if (reg_addr == addr_status) begin
            rd_val = {4'h0, state_q};
        end else begin
            rd_val = 8'h00;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_val : 8'h00;
        end
    end
endmodule : pmcc_top
